// ### rtl/ot_stop_defines.svh
// register map, field positions, reset values and limits of the overtravel stop block
`ifndef OT_STOP_DEFINES_SVH
`define OT_STOP_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OT_OFS_SWITCH_A 12'h000
`define OT_OFS_SWITCH_B 12'h004
`define OT_OFS_STOP_TRQ 12'h008
`define OT_OFS_CONTROL 12'h00c
`define OT_OFS_STATUS 12'h010

// ************************************************************
// field positions
// ************************************************************
`define OT_A_FWD_IGNORE 2
`define OT_A_REV_IGNORE 3
`define OT_A_COAST 6
`define OT_A_DB_HOLD 7
`define OT_A_DECEL 8
`define OT_A_ZCLAMP 9
`define OT_B_REVERSE 0
`define OT_C_TORQUE_MODE 0

// ************************************************************
// reset values and widths
// ************************************************************
`define OT_SW_W 16
`define OT_SW_A_RESET 16'h0080
`define OT_SW_B_RESET 16'h0000
`define OT_CTRL_RESET 1'b0
`define OT_TRQ_W 10
`define OT_LARGE_DRIVE_DW 20

`endif

// ### rtl/ot_stop_pkg.sv
// types shared by the overtravel stop block
package ot_stop_pkg;

    // stop sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DECEL,
        ST_ZCLAMP,
        ST_BRAKE
    } stop_state_e;

    // torque value in percent of rated torque
    typedef logic [9:0] torque_t;

endpackage : ot_stop_pkg

// ### rtl/ot_pin_sync.sv
// two-stage synchroniser for a group of contact inputs
`timescale 1ns/1ps
module ot_pin_sync #(
    parameter int WIDTH = 4
) (
    // clock, enable, reset
    input wire logic pclk,
    input wire logic ce,
    input wire logic presetn,
    // raw pins and their synchronised copies
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    // ************************************************************
    // one chain per pin
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_ff; // first stage, read only by the second
            logic sync_ff; // second stage, safe to use
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else if (ce) begin
                    meta_ff <= pin_in[gi];
                    sync_ff <= meta_ff;
                end
            end
            assign pin_sync[gi] = sync_ff;
        end
    endgenerate

endmodule : ot_pin_sync

// ### rtl/ot_quad_out.sv
// quadrature pulse generator for the encoder echo outputs
`timescale 1ns/1ps
module ot_quad_out (
    // clock, enable, reset
    input wire logic pclk,
    input wire logic ce,
    input wire logic presetn,
    // one step request and its direction
    input wire logic step,
    input wire logic count_up,
    // quadrature outputs
    output logic phase_a,
    output logic phase_b
);

    // ************************************************************
    // gray step counter
    // ************************************************************
    logic [1:0] pos_ff; // binary quarter-cycle position
    wire [1:0] nxt_pos = count_up ? pos_ff + 2'h1 : pos_ff - 2'h1;

    // phase a leads b when counting up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff <= 2'h0;
            phase_a <= 1'b0;
            phase_b <= 1'b0;
        end else if (ce && step) begin
            pos_ff <= nxt_pos;
            phase_a <= nxt_pos[1] ^ nxt_pos[0];
            phase_b <= nxt_pos[1];
        end
    end

endmodule : ot_quad_out

// ### rtl/ot_stop_ctrl.sv
// overtravel and servo-off stop decision logic with apb register access
//
// Notes on behaviour
// - direction bit 0: ccw forward; 1: cw
// - reverse mode flips references and encoder echo
// - direction change applies only after power cycle
// - forward limit high blocks forward only
// - reverse limit high or open blocks reverse
// - switch a bit 2 ignores forward limit
// - switch a bit 3 ignores reverse limit
// - active limit during run triggers overtravel stop
// - bit 8: servo-off stop or torque decel
// - after decel: bit 9 servo off/zero clamp
// - torque mode always uses servo-off stop
// - stop torque percent, clamp max, decel only
// - servo-off on contact off, alarm, power loss
// - bit 6: dynamic brake or coast
// - bit 7 keeps dynamic brake after stop
// - large drives force bit 7 to zero
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ot_stop_defines.svh"
module ot_stop_ctrl #(
    parameter int ADDR_W = 12,
    parameter int MAX_TORQUE_PCT = 300, // maximum torque in percent
    parameter int RATING_DW = 20 // drive rating in tenths of a kilowatt
) (
    // clock, enable, reset
    input wire logic pclk,
    input wire logic ce,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // contact pins from the machine and host
    input wire logic fwd_travel_limit_in,
    input wire logic rev_travel_limit_in,
    input wire logic servo_on_n,
    input wire logic power_ok,
    // same-clock inputs from the control loops
    input wire logic servo_alarm,
    input wire logic ref_fwd,
    input wire logic ref_rev,
    input wire logic motor_stopped,
    input wire logic enc_step,
    input wire logic enc_ccw,
    // drive outputs
    output logic motor_power_on,
    output logic dyn_brake_on,
    output logic decel_active,
    output ot_stop_pkg::torque_t emergency_stop_torque,
    output logic zero_clamp,
    output logic drive_ccw,
    output logic drive_cw,
    output logic fwd_allowed,
    output logic rev_allowed,
    output ot_stop_pkg::stop_state_e stop_state,
    // encoder echo
    output logic encoder_out_phase_a,
    output logic encoder_out_phase_b
);
    import ot_stop_pkg::*;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // offsets up to the status word need five address bits
    if (ADDR_W < 5) begin : g_addr_chk
        $error("address width too small for the register map");
    end
    // the torque setting is a ten bit field
    if (MAX_TORQUE_PCT < 1 || MAX_TORQUE_PCT > 1023) begin : g_trq_chk
        $error("maximum torque out of range");
    end

    localparam torque_t TRQ_MAX = torque_t'(MAX_TORQUE_PCT);
    localparam logic LARGE_DRIVE = (RATING_DW >= `OT_LARGE_DRIVE_DW);
    // large drives may never hold the brake, not even straight after reset
    localparam logic [`OT_SW_W-1:0] SW_A_INIT = LARGE_DRIVE ? (`OT_SW_A_RESET & ~(`OT_SW_W'(1) << `OT_A_DB_HOLD))
                                                            : `OT_SW_A_RESET;

    // ************************************************************
    // contact synchronisation
    // ************************************************************
    logic [3:0] pins_sync; // fwd, rev, servo-on, power
    ot_pin_sync #(.WIDTH(4)) u_sync (
        .pclk(pclk),
        .ce(ce),
        .presetn(presetn),
        .pin_in({power_ok, servo_on_n, rev_travel_limit_in, fwd_travel_limit_in}),
        .pin_sync(pins_sync)
    );
    wire fwd_lim = pins_sync[0]; // high: forward prohibited
    wire rev_lim = pins_sync[1]; // high or open: reverse prohibited
    wire son_n = pins_sync[2]; // low: servo on requested
    wire pwr = pins_sync[3]; // high: main power present

    // ************************************************************
    // registers
    // ************************************************************
    logic [`OT_SW_W-1:0] sw_a_ff; // function_switch_a
    logic [`OT_SW_W-1:0] sw_b_ff; // function_switch_b
    torque_t trq_ff; // stop_torque_setting
    logic tmode_ff; // torque control mode
    logic dir_rev_ff; // direction convention in force
    logic dir_cap_ff; // convention captured since reset
    logic pwr_d_ff; // power level one cycle ago
    stop_state_e state_ff; // stop sequencer state
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    // ************************************************************
    // apb decode
    // ************************************************************
    // one wait state so read data come from a flop
    wire apb_acc = psel && penable;
    wire apb_first = apb_acc && !pready_ff;
    wire apb_done = apb_acc && pready_ff;
    wire [ADDR_W-1:0] ofs = paddr;
    wire hit_a = (ofs == ADDR_W'(`OT_OFS_SWITCH_A));
    wire hit_b = (ofs == ADDR_W'(`OT_OFS_SWITCH_B));
    wire hit_t = (ofs == ADDR_W'(`OT_OFS_STOP_TRQ));
    wire hit_c = (ofs == ADDR_W'(`OT_OFS_CONTROL));
    wire hit_s = (ofs == ADDR_W'(`OT_OFS_STATUS));
    wire mapped = hit_a || hit_b || hit_t || hit_c || hit_s;
    wire wr_ok = apb_done && pwrite && mapped;

    // large drives cannot hold the brake after a stop
    wire [`OT_SW_W-1:0] nxt_sw_a = LARGE_DRIVE ? (pwdata[`OT_SW_W-1:0] & ~(`OT_SW_W'(1) << `OT_A_DB_HOLD))
                                                : pwdata[`OT_SW_W-1:0];
    // torque settings above the maximum clamp to it
    wire torque_t nxt_trq = (pwdata[31:`OT_TRQ_W] != '0 || pwdata[`OT_TRQ_W-1:0] > TRQ_MAX) ? TRQ_MAX
                                                                                          : pwdata[`OT_TRQ_W-1:0];

    // status word: state, permissions, convention, contacts
    wire [31:0] status_word = {21'h0, pwr, son_n, rev_lim, fwd_lim, dir_rev_ff,
                               rev_allowed, fwd_allowed, 1'b0, state_ff};
    wire [31:0] rd_mux = hit_a ? {16'h0, sw_a_ff} :
                         hit_b ? {16'h0, sw_b_ff} :
                         hit_t ? {22'h0, trq_ff} :
                         hit_c ? {31'h0, tmode_ff} :
                         hit_s ? status_word : 32'h0;

    // bus handshake and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else if (ce) begin
            pready_ff <= apb_first;
            pslverr_ff <= apb_first && !mapped; // unmapped answers with error
            if (apb_first && !pwrite) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    // writable registers take data at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_a_ff <= SW_A_INIT;
            sw_b_ff <= `OT_SW_B_RESET;
            trq_ff <= TRQ_MAX; // factory value is the maximum
            tmode_ff <= `OT_CTRL_RESET;
        end else if (ce && wr_ok) begin
            if (hit_a) sw_a_ff <= nxt_sw_a;
            if (hit_b) sw_b_ff <= pwdata[`OT_SW_W-1:0];
            if (hit_t) trq_ff <= nxt_trq;
            if (hit_c) tmode_ff <= pwdata[`OT_C_TORQUE_MODE];
        end
    end

    // ************************************************************
    // direction convention
    // ************************************************************
    // a new direction bit only lands on a power-up edge,
    // so a live edit never flips an axis in motion
    wire pwr_rise = pwr && !pwr_d_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_rev_ff <= 1'b0;
            dir_cap_ff <= 1'b0;
            pwr_d_ff <= 1'b0;
        end else if (ce) begin
            pwr_d_ff <= pwr;
            if (!dir_cap_ff || pwr_rise) begin
                dir_rev_ff <= sw_b_ff[`OT_B_REVERSE];
                dir_cap_ff <= 1'b1;
            end
        end
    end

    // ************************************************************
    // limit evaluation
    // ************************************************************
    wire ot_fwd = fwd_lim && !sw_a_ff[`OT_A_FWD_IGNORE];
    wire ot_rev = rev_lim && !sw_a_ff[`OT_A_REV_IGNORE];
    wire ot_hit = (ot_fwd && ref_fwd) || (ot_rev && ref_rev);
    wire off_cause = son_n || servo_alarm || !pwr;
    wire use_decel = sw_a_ff[`OT_A_DECEL] && !tmode_ff;

    // ************************************************************
    // stop sequencer
    // ************************************************************
    stop_state_e nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // servo off and stopped
            ST_IDLE: begin
                if (!off_cause && !ot_hit) nxt_state = ST_RUN;
            end
            // normal operation
            ST_RUN: begin
                if (off_cause) nxt_state = ST_BRAKE;
                else if (ot_hit && use_decel) nxt_state = ST_DECEL;
                else if (ot_hit) nxt_state = ST_BRAKE;
            end
            // decelerating at the emergency torque
            ST_DECEL: begin
                if (off_cause) nxt_state = ST_BRAKE;
                else if (motor_stopped && sw_a_ff[`OT_A_ZCLAMP]) nxt_state = ST_ZCLAMP;
                else if (motor_stopped) nxt_state = ST_IDLE;
            end
            // held at zero, leave when the way is clear
            ST_ZCLAMP: begin
                if (off_cause) nxt_state = ST_BRAKE;
                else if (!ot_hit) nxt_state = ST_RUN;
            end
            // braking or coasting with power off
            ST_BRAKE: begin
                if (motor_stopped) nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_ff <= ST_IDLE;
        else if (ce) state_ff <= nxt_state;
    end

    // ************************************************************
    // output decode
    // ************************************************************
    wire nxt_power = (state_ff == ST_RUN) || (state_ff == ST_DECEL) || (state_ff == ST_ZCLAMP);
    // brake while stopping unless coasting; after stop only if held
    wire nxt_db = !sw_a_ff[`OT_A_COAST] && ((state_ff == ST_BRAKE) ||
                  ((state_ff == ST_IDLE) && sw_a_ff[`OT_A_DB_HOLD]));
    wire nxt_decel = (state_ff == ST_DECEL);
    // references only move where allowed and while running
    wire run = (state_ff == ST_RUN);
    wire go_fwd = run && ref_fwd && !ot_fwd;
    wire go_rev = run && ref_rev && !ot_rev;
    // reverse mode swaps the physical sense of every reference
    wire nxt_ccw = dir_rev_ff ? go_rev : go_fwd;
    wire nxt_cw = dir_rev_ff ? go_fwd : go_rev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_power_on <= 1'b0;
            dyn_brake_on <= 1'b0;
            decel_active <= 1'b0;
            emergency_stop_torque <= '0;
            zero_clamp <= 1'b0;
            drive_ccw <= 1'b0;
            drive_cw <= 1'b0;
            fwd_allowed <= 1'b0;
            rev_allowed <= 1'b0;
            stop_state <= ST_IDLE;
        end else if (ce) begin
            motor_power_on <= nxt_power;
            dyn_brake_on <= nxt_db;
            decel_active <= nxt_decel;
            emergency_stop_torque <= nxt_decel ? trq_ff : '0;
            zero_clamp <= (state_ff == ST_ZCLAMP);
            drive_ccw <= nxt_ccw;
            drive_cw <= nxt_cw;
            fwd_allowed <= !ot_fwd;
            rev_allowed <= !ot_rev;
            stop_state <= state_ff;
        end
    end

    // ************************************************************
    // encoder echo
    // ************************************************************
    // forward in the active convention counts up on the echo
    ot_quad_out u_quad (
        .pclk(pclk),
        .ce(ce),
        .presetn(presetn),
        .step(enc_step),
        .count_up(enc_ccw ^ dir_rev_ff),
        .phase_a(encoder_out_phase_a),
        .phase_b(encoder_out_phase_b)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fwd_block_a: assert property (ce && ot_fwd |=> !fwd_allowed)
        else $error("forward allowed while forward limit active");
    fwd_ignore_a: assert property (ce && sw_a_ff[`OT_A_FWD_IGNORE] |=> fwd_allowed)
        else $error("forward blocked although limit ignored");
    rev_ignore_a: assert property (ce && (sw_a_ff[`OT_A_REV_IGNORE] || !rev_lim) |=> rev_allowed)
        else $error("reverse blocked although allowed");
    servo_off_a: assert property (ce && state_ff == ST_RUN && off_cause |=> state_ff == ST_BRAKE)
        else $error("run did not stop on servo-off cause");
    ot_decel_a: assert property (ce && state_ff == ST_RUN && !off_cause && ot_hit && use_decel
                                 |=> state_ff == ST_DECEL ##1 (decel_active || !$past(ce)))
        else $error("overtravel decel not entered");
    torque_mode_a: assert property (ce && state_ff == ST_RUN && !off_cause && ot_hit && tmode_ff
                                    |=> state_ff == ST_BRAKE)
        else $error("torque mode did not use servo-off stop");
    zclamp_entry_a: assert property (ce && state_ff == ST_DECEL && !off_cause && motor_stopped
                                     && sw_a_ff[`OT_A_ZCLAMP] |=> state_ff == ST_ZCLAMP)
        else $error("zero clamp not entered after decel");
    brake_kind_a: assert property (ce && state_ff == ST_BRAKE |=> dyn_brake_on == !$past(sw_a_ff[`OT_A_COAST]))
        else $error("brake output does not follow coast bit");
    large_hold_a: assert property (LARGE_DRIVE |-> !sw_a_ff[`OT_A_DB_HOLD])
        else $error("brake hold set on large drive");
    stop_torque_a: assert property (ce && state_ff == ST_DECEL |=> emergency_stop_torque == $past(trq_ff))
        else $error("decel torque differs from setting");
    dir_hold_a: assert property (ce && dir_cap_ff && !pwr_rise |=> $stable(dir_rev_ff))
        else $error("direction changed without power cycle");

    decel_seen_c: cover property (state_ff == ST_DECEL ##[1:50] state_ff == ST_ZCLAMP);
    brake_seen_c: cover property (state_ff == ST_RUN ##1 state_ff == ST_BRAKE ##[1:50] state_ff == ST_IDLE);
    rerun_seen_c: cover property (state_ff == ST_ZCLAMP ##1 state_ff == ST_RUN);

endmodule : ot_stop_ctrl

// ### verification/contact_model.sv
// contact model of the limit switches and the host servo-on contact
`timescale 1ns/1ps
module contact_model (
    // clock
    input wire logic pclk,
    // requested contact states
    input wire logic want_fwd,
    input wire logic want_rev,
    input wire logic want_on,
    input wire logic want_pwr,
    // pin levels
    output logic fwd_pin,
    output logic rev_pin,
    output logic son_n_pin,
    output logic pwr_pin
);
    // contacts move just after an edge; an open reverse switch reads high
    always @(posedge pclk) begin
        fwd_pin <= want_fwd;
        rev_pin <= want_rev;
        son_n_pin <= !want_on;
        pwr_pin <= want_pwr;
    end
endmodule : contact_model

// ### verification/ot_stop_ctrl_tb.sv
// self-checking bench of the overtravel stop block
`timescale 1ns/1ps
module ot_stop_ctrl_tb;
    import ot_stop_pkg::*;
    // ****
    // stimulus and observed signals
    // ****
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic want_fwd = 1'b0, want_rev = 1'b0, want_on = 1'b1, want_pwr = 1'b1;
    logic fwd_pin, rev_pin, son_n_pin, pwr_pin;
    logic servo_alarm = 1'b0, ref_fwd = 1'b0, ref_rev = 1'b0, motor_stopped = 1'b0;
    logic ce = 1'b1, enc_step = 1'b0, enc_ccw = 1'b0;
    logic encoder_out_phase_a, encoder_out_phase_b;
    logic motor_power_on, dyn_brake_on, decel_active, zero_clamp;
    logic drive_ccw, drive_cw, fwd_allowed, rev_allowed;
    torque_t emergency_stop_torque;
    stop_state_e stop_state;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] r;
    logic e;

    // 20 mhz clock
    always #25 pclk = ~pclk;

    contact_model u_contact_model (.pclk(pclk), .want_fwd(want_fwd), .want_rev(want_rev),
        .want_on(want_on), .want_pwr(want_pwr), .fwd_pin(fwd_pin), .rev_pin(rev_pin),
        .son_n_pin(son_n_pin), .pwr_pin(pwr_pin));

    ot_stop_ctrl u_ot_stop_ctrl (.pclk(pclk), .ce(ce), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fwd_travel_limit_in(fwd_pin),
        .rev_travel_limit_in(rev_pin), .servo_on_n(son_n_pin), .power_ok(pwr_pin),
        .servo_alarm(servo_alarm), .ref_fwd(ref_fwd), .ref_rev(ref_rev),
        .motor_stopped(motor_stopped), .enc_step(enc_step), .enc_ccw(enc_ccw),
        .motor_power_on(motor_power_on), .dyn_brake_on(dyn_brake_on), .decel_active(decel_active),
        .emergency_stop_torque(emergency_stop_torque), .zero_clamp(zero_clamp),
        .drive_ccw(drive_ccw), .drive_cw(drive_cw), .fwd_allowed(fwd_allowed),
        .rev_allowed(rev_allowed), .stop_state(stop_state), .encoder_out_phase_a(encoder_out_phase_a),
        .encoder_out_phase_b(encoder_out_phase_b));

    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) chk(32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask : rd_chk

    // bounded wait for the sequencer to settle in a state
    task automatic wait_st(input stop_state_e s);
        int n;
        n = 0;
        while (stop_state !== s && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk({29'h0, stop_state}, {29'h0, s});
    endtask : wait_st

    // one encoder quarter step, then the echo pair {a, b}
    task automatic enc_chk(input logic ccw, input logic [1:0] exp);
        enc_step <= 1'b1;
        enc_ccw <= ccw;
        @(posedge pclk);
        enc_step <= 1'b0;
        @(posedge pclk);
        chk({30'h0, encoder_out_phase_a, encoder_out_phase_b}, {30'h0, exp});
    endtask : enc_chk

    // ****
    // scenarios
    // ****
    task automatic t_reset_regs();
        rd_chk(12'h000, 32'h0, 1'b0);
        rd_chk(12'h004, 32'h0, 1'b0);
        rd_chk(12'h008, 32'd300, 1'b0);
        apb(1'b1, 12'h008, 32'h3ff);
        rd_chk(12'h008, 32'd300, 1'b0);
        rd_chk(12'h020, 32'h0, 1'b1);
        wait_st(ST_RUN);
        chk({31'h0, fwd_allowed & rev_allowed}, 32'h1);
    endtask : t_reset_regs

    task automatic t_decel_stop();
        apb(1'b1, 12'h000, 32'h180);
        rd_chk(12'h000, 32'h100, 1'b0);
        apb(1'b1, 12'h008, 32'd50);
        ref_rev <= 1'b1;
        want_rev <= 1'b1;
        wait_st(ST_DECEL);
        chk({31'h0, decel_active}, 32'h1);
        chk({22'h0, emergency_stop_torque}, 32'd50);
        chk({30'h0, fwd_allowed, rev_allowed}, 32'h2);
        motor_stopped <= 1'b1;
        wait_st(ST_IDLE);
        chk({31'h0, motor_power_on}, 32'h0);
        motor_stopped <= 1'b0;
        want_rev <= 1'b0;
        wait_st(ST_RUN);
    endtask : t_decel_stop

    task automatic t_zero_clamp();
        apb(1'b1, 12'h000, 32'h300);
        want_rev <= 1'b1;
        motor_stopped <= 1'b1;
        wait_st(ST_ZCLAMP);
        chk({31'h0, zero_clamp}, 32'h1);
        want_rev <= 1'b0;
        wait_st(ST_RUN);
        motor_stopped <= 1'b0;
    endtask : t_zero_clamp

    task automatic t_ignore_limits();
        apb(1'b1, 12'h000, 32'h10c);
        ref_fwd <= 1'b1;
        want_fwd <= 1'b1;
        want_rev <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({29'h0, stop_state}, {29'h0, ST_RUN});
        chk({30'h0, fwd_allowed, rev_allowed}, 32'h3);
        want_rev <= 1'b0;
        ref_rev <= 1'b0;
    endtask : t_ignore_limits

    task automatic t_torque_mode();
        apb(1'b1, 12'h00c, 32'h1);
        apb(1'b1, 12'h000, 32'h100);
        wait_st(ST_BRAKE);
        chk({31'h0, dyn_brake_on}, 32'h1);
        motor_stopped <= 1'b1;
        wait_st(ST_IDLE);
        chk({31'h0, dyn_brake_on}, 32'h0);
        want_fwd <= 1'b0;
        apb(1'b1, 12'h00c, 32'h0);
        motor_stopped <= 1'b0;
        wait_st(ST_RUN);
    endtask : t_torque_mode

    task automatic t_servo_off();
        apb(1'b1, 12'h000, 32'h40);
        ce <= 1'b0;
        want_on <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({29'h0, stop_state}, {29'h0, ST_RUN});
        ce <= 1'b1;
        wait_st(ST_BRAKE);
        chk({30'h0, dyn_brake_on, motor_power_on}, 32'h0);
        motor_stopped <= 1'b1;
        wait_st(ST_IDLE);
        want_on <= 1'b1;
        motor_stopped <= 1'b0;
        wait_st(ST_RUN);
        servo_alarm <= 1'b1;
        wait_st(ST_BRAKE);
        servo_alarm <= 1'b0;
        motor_stopped <= 1'b1;
        wait_st(ST_RUN);
        motor_stopped <= 1'b0;
    endtask : t_servo_off

    // new direction waits for a power cycle
    task automatic t_direction();
        enc_chk(1'b1, 2'b10);
        apb(1'b1, 12'h004, 32'h1);
        repeat (3) @(posedge pclk);
        chk({30'h0, drive_ccw, drive_cw}, 32'h2);
        want_pwr <= 1'b0;
        motor_stopped <= 1'b1;
        wait_st(ST_IDLE);
        want_pwr <= 1'b1;
        wait_st(ST_RUN);
        repeat (3) @(posedge pclk);
        chk({30'h0, drive_ccw, drive_cw}, 32'h1);
        enc_chk(1'b0, 2'b11);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, r[6]}, 32'h1);
    endtask : t_direction

    task automatic tally_and_finish();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard, far above the few hundred cycles needed
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_regs();
        t_decel_stop();
        t_zero_clamp();
        t_ignore_limits();
        t_torque_mode();
        t_servo_off();
        t_direction();
        tally_and_finish();
    end
endmodule : ot_stop_ctrl_tb
